// [include/mseq_pkg.sv]
// constants and types shared by the measurement sequencer
package mseq_pkg;
  // timing, every time in nanoseconds, and the derived cycle counts
  localparam int CLK_PERIOD_NS = 8;
  localparam int PD_START_NS = 1200000;
  localparam int SB_WAKE_NS = 4000;
  localparam int PAUSE_STEP_NS = 8000;
  localparam int PD_START_CYC = (PD_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SB_WAKE_CYC = (SB_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAUSE_STEP_CYC = (PAUSE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 20;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_STATE = 8'h00;
  localparam logic [7:0] OFS_CFG2 = 8'h04;
  localparam logic [7:0] OFS_CFG3 = 8'h08;
  localparam logic [7:0] OFS_EDGES = 8'h0c;
  localparam logic [7:0] OFS_PAUSE = 8'h10;
  localparam logic [7:0] OFS_CONVTIME = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_CONVCOUNT = 8'h1c;

  // field positions
  localparam int START_BIT = 7;
  localparam int PD_BIT = 6;
  localparam int TM_BIT = 6;
  localparam int SB_BIT = 3;
  localparam int MODE_LSB = 0;
  localparam int ST_READY_BIT = 0;
  localparam int ST_VALID_BIT = 1;
  localparam int ST_ANALOG_BIT = 2;
  localparam int ST_STBY_BIT = 3;
  localparam int ST_FSM_LSB = 4;

  // device state field codes
  localparam logic [2:0] DOS_NOP = 3'h0;
  localparam logic [2:0] DOS_CONFIG = 3'h2;
  localparam logic [2:0] DOS_MEASURE = 3'h3;

  // reset values
  localparam logic [7:0] STATE_RST = 8'h42;
  localparam logic [7:0] EDGES_RST = 8'h01;
  localparam logic [7:0] PAUSE_RST = 8'h14;
  localparam logic [15:0] CONVTIME_RST = 16'h1000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_CONTINUOUS_MODE = 2'h0,
    MODE_CMD = 2'h1,
    MODE_SYNC_START_MODE = 2'h2,
    MODE_SYNC_START_STOP_MODE = 2'h3
  } mseq_mode_t;

  typedef enum logic [2:0] {
    ST_PWRDN,
    ST_PDSTART,
    ST_STBY,
    ST_SBSTART,
    ST_IDLE,
    ST_CONV,
    ST_PAUSE
  } mseq_state_t;
endpackage

// [src/mseq_top.sv]
// measurement sequencer with power states and an AXI4-Lite register slave
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module mseq_top #(
  parameter int PD_START_CYCLES = mseq_pkg::PD_START_CYC,
  parameter int SB_WAKE_CYCLES = mseq_pkg::SB_WAKE_CYC,
  parameter int PAUSE_STEP_CYCLES = mseq_pkg::PAUSE_STEP_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [mseq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [mseq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic syncIn,
  output logic readyPin,
  output logic analogOn,
  output logic standbyOn,
  output logic resultStore,
  output logic resultClear
);

  typedef logic [mseq_pkg::TMR_W-1:0] mseq_tmr_t;

  typedef struct packed {
    mseq_pkg::mseq_state_t fsm;
    mseq_tmr_t tmr;
    logic pending;
    logic [7:0] edgeCnt;
    logic [23:0] convCnt;
    logic [23:0] convCount;
    logic resultValid;
    logic syncPrev;
    logic start;
    logic pd;
    logic [2:0] device_state_field;
    logic tm;
    logic sb;
    mseq_pkg::mseq_mode_t mode;
    logic [7:0] edges;
    logic [7:0] pause;
    logic [15:0] convTime;
    logic readyPin;
    logic analogOn;
    logic standbyOn;
    logic resultStore;
    logic resultClear;
    logic awReady;
    logic awHeld;
    logic [mseq_pkg::ADDR_W-1:0] awAddr;
    logic wReady;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } mseq_regs_t;

  mseq_regs_t r;
  mseq_regs_t next_r;

  // register read view; unmapped offsets read zero
  function automatic logic [31:0] readView(input mseq_regs_t s,
                                           input logic [mseq_pkg::ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      mseq_pkg::OFS_STATE: begin
        v[mseq_pkg::START_BIT] = s.start;
        v[mseq_pkg::PD_BIT] = s.pd;
        v[2:0] = s.device_state_field;
      end
      mseq_pkg::OFS_CFG2: v[mseq_pkg::TM_BIT] = s.tm;
      mseq_pkg::OFS_CFG3: begin
        v[mseq_pkg::SB_BIT] = s.sb;
        v[mseq_pkg::MODE_LSB +: 2] = s.mode;
      end
      mseq_pkg::OFS_EDGES: v[7:0] = s.edges;
      mseq_pkg::OFS_PAUSE: v[7:0] = s.pause;
      mseq_pkg::OFS_CONVTIME: v[15:0] = s.convTime;
      mseq_pkg::OFS_STATUS: begin
        v[mseq_pkg::ST_READY_BIT] = s.readyPin;
        v[mseq_pkg::ST_VALID_BIT] = s.resultValid;
        v[mseq_pkg::ST_ANALOG_BIT] = s.analogOn;
        v[mseq_pkg::ST_STBY_BIT] = s.standbyOn;
        v[mseq_pkg::ST_FSM_LSB +: 3] = s.fsm;
      end
      mseq_pkg::OFS_CONVCOUNT: v[23:0] = s.convCount;
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [mseq_pkg::ADDR_W-1:0] a);
    return a == mseq_pkg::OFS_STATE || a == mseq_pkg::OFS_CFG2 || a == mseq_pkg::OFS_CFG3 ||
           a == mseq_pkg::OFS_EDGES || a == mseq_pkg::OFS_PAUSE ||
           a == mseq_pkg::OFS_CONVTIME || a == mseq_pkg::OFS_STATUS ||
           a == mseq_pkg::OFS_CONVCOUNT;
  endfunction

  logic fall;
  logic measure;
  logic cfgState;
  logic trigger;
  logic abort;
  logic tmrDone;
  logic convEnd;
  logic goConv;
  logic goRest;
  logic goSb;
  logic [31:0] mask;
  logic [31:0] wd;

  // sequencer, then the register slave; bus writes are applied last so they win
  always_comb begin
    next_r = r;
    next_r.syncPrev = syncIn;
    next_r.resultStore = 1'b0;
    next_r.resultClear = 1'b0;
    fall = r.syncPrev & ~syncIn;
    measure = r.device_state_field == mseq_pkg::DOS_MEASURE;
    cfgState = r.device_state_field == mseq_pkg::DOS_CONFIG;
    // start bit alone for command and continuous, plus an edge for sync modes
    trigger = measure & r.start &
              ((r.mode == mseq_pkg::MODE_CONTINUOUS_MODE) | (r.mode == mseq_pkg::MODE_CMD) | fall);
    abort = ~measure | ~r.start;
    tmrDone = r.tmr == '0;
    convEnd = 1'b0;
    goConv = 1'b0;
    goRest = 1'b0;
    goSb = 1'b0;
    mask = 32'h0;
    wd = 32'h0;
    if (!tmrDone) begin
      next_r.tmr = r.tmr - mseq_tmr_t'(1);
    end
    case (r.fsm)
      mseq_pkg::ST_PWRDN: begin
        if (trigger) begin
          next_r.fsm = mseq_pkg::ST_PDSTART;
          next_r.pending = 1'b1;
          next_r.tmr = mseq_tmr_t'(PD_START_CYCLES - 1);
        end else if (!r.pd) begin
          next_r.fsm = mseq_pkg::ST_PDSTART;
          next_r.pending = 1'b0;
          next_r.tmr = mseq_tmr_t'(PD_START_CYCLES - 1);
        end
      end
      mseq_pkg::ST_PDSTART: begin
        if (tmrDone) begin
          if (r.pending && !abort && r.sb) begin
            goSb = 1'b1;
          end else if (r.pending && !abort) begin
            goConv = 1'b1;
          end else if (r.pending) begin
            goRest = 1'b1;
          end else begin
            next_r.fsm = r.sb ? mseq_pkg::ST_STBY : mseq_pkg::ST_IDLE;
          end
        end
      end
      mseq_pkg::ST_STBY: begin
        if (r.pd) begin
          next_r.fsm = mseq_pkg::ST_PWRDN;
        end else if (trigger) begin
          goSb = 1'b1;
        end else if (!r.sb) begin
          next_r.fsm = mseq_pkg::ST_IDLE;
        end
      end
      mseq_pkg::ST_SBSTART: begin
        if (tmrDone) begin
          if (r.pending && !abort) begin
            goConv = 1'b1;
          end else begin
            goRest = 1'b1;
          end
        end
      end
      mseq_pkg::ST_IDLE: begin
        if (trigger) begin
          goConv = 1'b1;
        end else if (r.pd || r.sb) begin
          goRest = 1'b1;
        end
      end
      mseq_pkg::ST_CONV: begin
        next_r.convCnt = r.convCnt + 24'h000001;
        if (fall) begin
          next_r.edgeCnt = r.edgeCnt + 8'h01;
        end
        if (r.mode == mseq_pkg::MODE_SYNC_START_STOP_MODE) begin
          // edge count of zero behaves as one
          convEnd = fall && ({1'b0, r.edgeCnt} + 9'h001 >= {1'b0, r.edges});
        end else begin
          convEnd = tmrDone;
        end
        if (abort) begin
          goRest = 1'b1;
        end else if (convEnd) begin
          next_r.resultStore = 1'b1;
          next_r.resultValid = 1'b1;
          if (r.mode == mseq_pkg::MODE_SYNC_START_STOP_MODE && r.tm) begin
            next_r.convCount = r.convCnt + 24'h000001;
          end
          if (r.mode == mseq_pkg::MODE_CMD) begin
            next_r.start = 1'b0;
            goRest = 1'b1;
          end else begin
            next_r.fsm = mseq_pkg::ST_PAUSE;
            next_r.tmr = (r.pause == 8'h00) ? '0 :
                         mseq_tmr_t'(int'(r.pause) * PAUSE_STEP_CYCLES - 1);
          end
        end
      end
      mseq_pkg::ST_PAUSE: begin
        // no edge handling here, so edges during the pause are dropped
        if (abort) begin
          goRest = 1'b1;
        end else if (tmrDone) begin
          if (r.mode == mseq_pkg::MODE_CONTINUOUS_MODE && r.sb) begin
            goSb = 1'b1;
          end else if (r.mode == mseq_pkg::MODE_CONTINUOUS_MODE) begin
            goConv = 1'b1;
          end else begin
            goRest = 1'b1;
          end
        end
      end
      default: next_r.fsm = mseq_pkg::ST_PWRDN;
    endcase
    if (goConv) begin
      next_r.fsm = mseq_pkg::ST_CONV;
      next_r.tmr = (r.convTime == 16'h0000) ? '0 : mseq_tmr_t'(r.convTime - 16'h0001);
      next_r.edgeCnt = 8'h00;
      next_r.convCnt = 24'h000000;
      next_r.pending = 1'b0;
    end
    if (goSb) begin
      next_r.fsm = mseq_pkg::ST_SBSTART;
      next_r.pending = 1'b1;
      next_r.tmr = mseq_tmr_t'(SB_WAKE_CYCLES - 1);
    end
    if (goRest) begin
      // saving state chosen only once the measurement is over
      next_r.pending = 1'b0;
      if (r.pd) begin
        next_r.fsm = mseq_pkg::ST_PWRDN;
      end else if (r.sb) begin
        next_r.fsm = mseq_pkg::ST_STBY;
      end else begin
        next_r.fsm = mseq_pkg::ST_IDLE;
      end
    end

    // write address and data are taken in either order
    if (s_axi_awvalid && r.awReady) begin
      next_r.awHeld = 1'b1;
      next_r.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wReady) begin
      next_r.wHeld = 1'b1;
      next_r.wData = s_axi_wdata;
      next_r.wStrb = s_axi_wstrb;
    end
    if (r.bValid && s_axi_bready) begin
      next_r.bValid = 1'b0;
    end
    if (r.awHeld && r.wHeld && !r.bValid) begin
      next_r.awHeld = 1'b0;
      next_r.wHeld = 1'b0;
      next_r.bValid = 1'b1;
      next_r.bResp = mapped(r.awAddr) ? mseq_pkg::RESP_OKAY : mseq_pkg::RESP_SLVERR;
      for (int i = 0; i < 4; i++) begin
        mask[i*8 +: 8] = {8{r.wStrb[i]}};
      end
      wd = (readView(r, r.awAddr) & ~mask) | (r.wData & mask);
      case (r.awAddr)
        mseq_pkg::OFS_STATE: begin
          // a software set of start wins over the end-of-command clear above
          next_r.start = wd[mseq_pkg::START_BIT];
          next_r.pd = wd[mseq_pkg::PD_BIT];
          if (wd[2:0] == mseq_pkg::DOS_CONFIG) begin
            next_r.device_state_field = mseq_pkg::DOS_CONFIG;
            if (measure) begin
              next_r.resultClear = 1'b1;
              next_r.resultValid = 1'b0;
              next_r.convCount = 24'h000000;
              // stop at once: a conversion ending in this very cycle stores nothing
              next_r.resultStore = 1'b0;
              if (next_r.fsm == mseq_pkg::ST_CONV || next_r.fsm == mseq_pkg::ST_PAUSE) begin
                next_r.fsm = next_r.pd ? mseq_pkg::ST_PWRDN :
                             (r.sb ? mseq_pkg::ST_STBY : mseq_pkg::ST_IDLE);
              end
            end
          end else if (wd[2:0] == mseq_pkg::DOS_MEASURE) begin
            next_r.device_state_field = mseq_pkg::DOS_MEASURE;
          end
        end
        mseq_pkg::OFS_CFG2: begin
          if (cfgState) begin
            next_r.tm = wd[mseq_pkg::TM_BIT];
          end
        end
        mseq_pkg::OFS_CFG3: begin
          if (cfgState) begin
            next_r.sb = wd[mseq_pkg::SB_BIT];
            next_r.mode = mseq_pkg::mseq_mode_t'(wd[mseq_pkg::MODE_LSB +: 2]);
          end
        end
        mseq_pkg::OFS_EDGES: begin
          if (cfgState) begin
            next_r.edges = wd[7:0];
          end
        end
        mseq_pkg::OFS_PAUSE: begin
          if (cfgState) begin
            next_r.pause = wd[7:0];
          end
        end
        mseq_pkg::OFS_CONVTIME: begin
          if (cfgState) begin
            next_r.convTime = wd[15:0];
          end
        end
        default: next_r.bResp = next_r.bResp;
      endcase
    end
    // one write at a time: channels reopen once the response is gone
    next_r.awReady = !next_r.awHeld && !next_r.bValid && !(r.awHeld && r.wHeld);
    next_r.wReady = !next_r.wHeld && !next_r.bValid && !(r.awHeld && r.wHeld);

    // read: one outstanding, data taken from the current register view
    if (r.rValid && s_axi_rready) begin
      next_r.rValid = 1'b0;
    end
    if (s_axi_arvalid && r.arReady) begin
      next_r.rValid = 1'b1;
      next_r.rData = readView(r, s_axi_araddr);
      next_r.rResp = mapped(s_axi_araddr) ? mseq_pkg::RESP_OKAY : mseq_pkg::RESP_SLVERR;
    end
    next_r.arReady = !next_r.rValid && !(s_axi_arvalid && r.arReady);

    // pins follow the next state so they change with it
    next_r.readyPin = next_r.fsm != mseq_pkg::ST_CONV;
    next_r.analogOn = next_r.fsm != mseq_pkg::ST_PWRDN;
    next_r.standbyOn = (next_r.fsm == mseq_pkg::ST_STBY) ||
                       (next_r.fsm == mseq_pkg::ST_PAUSE && next_r.sb);
  end

  // single state register; reset lands in power-down and configuration
  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
      r.fsm <= mseq_pkg::ST_PWRDN;
      r.start <= mseq_pkg::STATE_RST[mseq_pkg::START_BIT];
      r.pd <= mseq_pkg::STATE_RST[mseq_pkg::PD_BIT];
      r.device_state_field <= mseq_pkg::STATE_RST[2:0];
      r.mode <= mseq_pkg::MODE_CONTINUOUS_MODE;
      r.edges <= mseq_pkg::EDGES_RST;
      r.pause <= mseq_pkg::PAUSE_RST;
      r.convTime <= mseq_pkg::CONVTIME_RST;
      r.readyPin <= 1'b1;
      r.syncPrev <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awReady;
  assign s_axi_wready = r.wReady;
  assign s_axi_bvalid = r.bValid;
  assign s_axi_bresp = r.bResp;
  assign s_axi_arready = r.arReady;
  assign s_axi_rvalid = r.rValid;
  assign s_axi_rdata = r.rData;
  assign s_axi_rresp = r.rResp;
  assign readyPin = r.readyPin;
  assign analogOn = r.analogOn;
  assign standbyOn = r.standbyOn;
  assign resultStore = r.resultStore;
  assign resultClear = r.resultClear;

endmodule

// [bench/mseq_top_properties.sv]
// concurrent checks on the measurement sequencer ports
`timescale 1ns/10ps
module mseq_top_properties #(
  parameter int PD_START_CYCLES = 20,
  parameter int SB_WAKE_CYCLES = 5,
  parameter int PAUSE_STEP_CYCLES = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic readyPin,
  input wire logic analogOn,
  input wire logic standbyOn,
  input wire logic resultStore,
  input wire logic resultClear
);
  int pdCnt;
  int sbCnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // cycles since the analog side came up and since standby was left; both
  // saturate so a long quiet stretch never wraps into a false short count
  always_ff @(posedge clk) begin
    if (reset || !analogOn) pdCnt <= 0;
    else if (pdCnt < 100000) pdCnt <= pdCnt + 1;
    if (reset) sbCnt <= 100000;
    else if (standbyOn) sbCnt <= 0;
    else if (sbCnt < 100000) sbCnt <= sbCnt + 1;
  end

  a_store_at_end: assert property (resultStore |-> $rose(readyPin))
    else $error("result stored without conversion end");
  a_store_single: assert property (resultStore |=> !resultStore)
    else $error("result store longer than one cycle");
  a_clear_stops: assert property (resultClear |-> readyPin && !resultStore)
    else $error("clear left conversion running or stored");
  a_pd_quiet: assert property (!analogOn |-> readyPin && !standbyOn)
    else $error("activity while powered down");
  a_stby_quiet: assert property (standbyOn |-> readyPin)
    else $error("conversion while in standby");
  a_start_delay: assert property ($fell(readyPin) |-> pdCnt >= PD_START_CYCLES)
    else $error("conversion before startup delay ran out");
  a_sb_wake: assert property ($fell(readyPin) |-> sbCnt >= SB_WAKE_CYCLES)
    else $error("conversion before standby wake-up ran out");
  a_wake_first: assert property ($fell(readyPin) |-> analogOn && !standbyOn)
    else $error("ready fell while not awake");
  a_reset_idle: assert property (disable iff (1'b0)
    $fell(reset) |-> readyPin && !analogOn && !s_axi_bvalid)
    else $error("outputs not at rest after reset");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated after handshake");
  a_rdata_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated after handshake");
endmodule

// [bench/mseq_host_model.sv]
// host model: register bus master and sync pin driver
`timescale 1ns/10ps
module mseq_host_model (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic syncIn
);
  logic [1:0] lastResp;

  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    syncIn = 1'b1;
  end

  // released address and data lines show the inverse so stale values cannot pass as held ones;
  // bready and rready stand high with the request until the answer is sampled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid && bready) break;
    end
    bready <= 1'b0;
    lastResp = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid && rready) break;
    end
    rready <= 1'b0;
    d = rdata;
    lastResp = rresp;
  endtask

  // one falling sync edge; the next one comes gap edges later
  task automatic fall(input int gap);
    @(posedge clk);
    syncIn <= 1'b0;
    @(posedge clk);
    syncIn <= 1'b1;
    repeat (gap - 2) @(posedge clk);
  endtask
endmodule

// [bench/testbench.sv]
// self-checking bench for the measurement sequencer
`timescale 1ns/10ps
module testbench;
  localparam int PDC = 20;
  localparam int SBC = 5;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, syncIn;
  logic readyPin, analogOn, standbyOn, resultStore, resultClear;
  int n_errors = 0;
  int samples_checked = 0;
  int lowCnt = 0;
  int storeCnt = 0;
  int clearCnt = 0;

  always #4 clk = ~clk;

  mseq_top #(.PD_START_CYCLES(PDC), .SB_WAKE_CYCLES(SBC), .PAUSE_STEP_CYCLES(3)) u_mseq_top (
    .clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .syncIn(syncIn), .readyPin(readyPin), .analogOn(analogOn), .standbyOn(standbyOn),
    .resultStore(resultStore), .resultClear(resultClear));

  mseq_host_model u_host (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .syncIn(syncIn));

  // reference counts: conversion cycles, stores and clears seen at the pins
  always @(posedge clk) begin
    if (!readyPin) lowCnt++;
    if (resultStore) storeCnt++;
    if (resultClear) clearCnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string w);
    logic [31:0] d;
    u_host.rd(a, d);
    check(d & m, e, w);
  endtask

  // bounded wait for a ready level, sampled on falling clock edges
  task automatic waitRdy(input logic lvl, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (readyPin !== lvl && n < 5000);
    check(readyPin, {31'h0, lvl}, "ready level reached");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    logic [31:0] d;
    int n;
    int gap;
    int s;
    void'($urandom(94565));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check(readyPin, 32'h1, "ready after reset");
    check(analogOn, 32'h0, "analog after reset");
    rdc(mseq_pkg::OFS_STATE, 32'hff, {24'h0, mseq_pkg::STATE_RST}, "state reset");
    u_host.rd(8'h20, d);
    check(u_host.lastResp, mseq_pkg::RESP_SLVERR, "unmapped read");
    $display("test reset done");
    // startup without wake-up, then sync start-stop setup with time measure on
    u_host.wr(mseq_pkg::OFS_STATE, 32'h02);
    @(negedge clk);
    check(readyPin, 32'h1, "ready during startup");
    repeat (PDC + 3) @(negedge clk);
    check(analogOn, 32'h1, "awake");
    u_host.wr(mseq_pkg::OFS_CFG2, 32'h40);
    u_host.wr(mseq_pkg::OFS_CFG3, 32'h03);
    u_host.wr(mseq_pkg::OFS_EDGES, 32'h02);
    u_host.wr(mseq_pkg::OFS_PAUSE, 32'h08);
    u_host.wr(mseq_pkg::OFS_STATE, 32'h03);
    u_host.wr(mseq_pkg::OFS_STATE, 32'h83);
    // start edge, one continuing edge, stop edge, then one edge inside the pause
    gap = 4 + ($urandom % 8);
    lowCnt = 0;
    s = storeCnt;
    repeat (4) u_host.fall(gap);
    repeat (8) @(negedge clk);
    check(lowCnt, 2 * gap, "sync conversion length");
    check(storeCnt, s + 1, "one result stored");
    check(readyPin, 32'h1, "pause edge ignored");
    rdc(mseq_pkg::OFS_CONVCOUNT, 32'hffffff, 2 * gap, "cycle count");
    $display("test sync done");
    // abort a running conversion by returning to configuration
    repeat (30) @(negedge clk);
    s = storeCnt;
    u_host.fall(4);
    check(readyPin, 32'h0, "first edge starts");
    u_host.wr(mseq_pkg::OFS_STATE, 32'h02);
    @(negedge clk);
    check(readyPin, 32'h1, "aborted");
    check(clearCnt, 32'h1, "results cleared");
    check(storeCnt, s, "nothing stored");
    $display("test abort done");
    // standby bit accepted in configuration only
    u_host.wr(mseq_pkg::OFS_CFG3, 32'h09);
    u_host.wr(mseq_pkg::OFS_CONVTIME, 32'h0a);
    u_host.wr(mseq_pkg::OFS_STATE, 32'h03);
    u_host.wr(mseq_pkg::OFS_CFG3, 32'h01);
    rdc(mseq_pkg::OFS_CFG3, 32'hff, 32'h09, "standby kept");
    $display("test standby bit done");
    // command conversion out of standby returns to standby
    check(standbyOn, 32'h1, "resting in standby");
    u_host.wr(mseq_pkg::OFS_STATE, 32'h83);
    lowCnt = 0;
    waitRdy(1'b0, n);
    waitRdy(1'b1, n);
    repeat (3) @(negedge clk);
    check(lowCnt, 32'ha, "command length");
    check(standbyOn, 32'h1, "back to standby");
    rdc(mseq_pkg::OFS_STATE, 32'hff, 32'h03, "start cleared");
    $display("test standby done");
    // power-down with standby: startup then wake-up, then back to power-down
    u_host.wr(mseq_pkg::OFS_STATE, 32'hc3);
    waitRdy(1'b0, n);
    check(n >= PDC + SBC - 2, 32'h1, "startup then wake-up");
    waitRdy(1'b1, n);
    repeat (3) @(negedge clk);
    check(analogOn, 32'h0, "back in power-down");
    rdc(mseq_pkg::OFS_STATE, 32'hff, 32'h43, "power-down kept");
    repeat (PDC + 5) @(negedge clk);
    check(analogOn, 32'h0, "no wake without start");
    $display("test power-down done");
    // power-down requested mid-conversion waits for the conversion end
    u_host.wr(mseq_pkg::OFS_STATE, 32'h03);
    repeat (PDC + 4) @(negedge clk);
    check(standbyOn, 32'h1, "standby after startup");
    s = storeCnt;
    u_host.wr(mseq_pkg::OFS_STATE, 32'h83);
    waitRdy(1'b0, n);
    u_host.wr(mseq_pkg::OFS_STATE, 32'hc0);
    check(readyPin, 32'h0, "still converting");
    waitRdy(1'b1, n);
    repeat (3) @(negedge clk);
    check(storeCnt, s + 1, "stored before power-down");
    check(analogOn, 32'h0, "power-down after end");
    $display("test late power-down done");
    results();
  end
endmodule

bind mseq_top mseq_top_properties #(.PD_START_CYCLES(PD_START_CYCLES),
  .SB_WAKE_CYCLES(SB_WAKE_CYCLES), .PAUSE_STEP_CYCLES(PAUSE_STEP_CYCLES)) u_props (
  .clk(clk), .reset(reset), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .readyPin(readyPin), .analogOn(analogOn),
  .standbyOn(standbyOn), .resultStore(resultStore), .resultClear(resultClear));
